// *** src/remote_channel.v ***
`timescale 1ns/10ps
`include "temp_result_regs.vh"

module remote_channel (
    mclk,
    rst_b,
    upd,
    hi_new,
    frac_new,
    lo_read,
    hi_read,
    hi_out,
    lo_out,
    frozen
);
    input  wire       mclk;
    input  wire       rst_b;
    input  wire       upd;
    input  wire [7:0] hi_new;
    input  wire [1:0] frac_new;
    input  wire       lo_read;
    input  wire       hi_read;
    output wire [7:0] hi_out;
    output wire [7:0] lo_out;
    output wire       frozen;

    reg  [7:0] hi_live_q;
    reg  [7:0] hi_shown_q;
    reg  [7:0] hi_shown_d;
    reg  [7:0] lo_q;
    reg        frozen_q;

    // live copy keeps tracking so the view catches up one cycle after the freeze clears
    always @* begin
        hi_shown_d = hi_shown_q;
        if (!(frozen_q || lo_read)) begin
            hi_shown_d = upd ? hi_new : hi_live_q;
        end
    end

    always @(posedge mclk) begin
        if (!rst_b) begin
            hi_live_q  <= `RESULT_RESET;
            hi_shown_q <= `RESULT_RESET;
            lo_q       <= `RESULT_RESET;
            frozen_q   <= 1'b0;
        end else begin
            hi_shown_q <= hi_shown_d;
            if (upd) begin
                hi_live_q <= hi_new;
                lo_q      <= {frac_new, 6'h00};
            end
            if (lo_read) begin
                frozen_q <= 1'b1;
            end else if (hi_read) begin
                frozen_q <= 1'b0;
            end
        end
    end

    assign hi_out = hi_shown_q;
    assign lo_out = lo_q;
    assign frozen = frozen_q;
endmodule // remote_channel

// *** src/temp_encoder.v ***
`timescale 1ns/10ps
`include "temp_result_regs.vh"

module temp_encoder (
    deg,
    ext_range,
    code,
    clamped
);
    input  wire [9:0] deg;
    input  wire       ext_range;
    output reg  [7:0] code;
    output reg        clamped;

    wire signed [10:0] deg_s   = $signed({deg[9], deg});
    wire signed [10:0] ext_sum = deg_s + `EXT_OFFSET;

    always @* begin
        code    = 8'h00;
        clamped = 1'b0;
        if (ext_range) begin
            // offset binary, register span -64..+191 degrees
            if (ext_sum < 11'sd0) begin
                clamped = 1'b1;
            end else if (ext_sum > `EXT_MAX) begin
                code    = 8'hff;
                clamped = 1'b1;
            end else begin
                code = ext_sum[7:0];
            end
        end else begin
            // plain binary pinned to 0..127
            if (deg_s < 11'sd0) begin
                clamped = 1'b1;
            end else if (deg_s > `DEF_MAX) begin
                code    = 8'h7f;
                clamped = 1'b1;
            end else begin
                code = deg_s[7:0];
            end
        end
    end
endmodule // temp_encoder

// *** src/temp_result_register_map.v ***
`timescale 1ns/10ps
`include "temp_result_regs.vh"

module temp_result_register_map (
    mclk,
    rst_b,
    wr_valid,
    wr_first,
    wr_byte,
    rd_req,
    conv_valid,
    conv_chan,
    conv_deg,
    conv_frac,
    rd_data,
    rd_valid,
    pointer,
    cfg_one,
    cfg_two,
    ext_range,
    standby,
    locked,
    r1_frozen,
    r2_frozen
);
    input  wire       mclk;
    input  wire       rst_b;
    input  wire       wr_valid;
    input  wire       wr_first;
    input  wire [7:0] wr_byte;
    input  wire       rd_req;
    input  wire       conv_valid;
    input  wire [1:0] conv_chan;
    input  wire [9:0] conv_deg;
    input  wire [1:0] conv_frac;
    output reg  [7:0] rd_data;
    output reg        rd_valid;
    output wire [7:0] pointer;
    output wire [7:0] cfg_one;
    output wire [7:0] cfg_two;
    output wire       ext_range;
    output wire       standby;
    output wire       locked;
    output reg        r1_frozen;
    output reg        r2_frozen;

    // ****************************************
    // state
    // ****************************************
    reg  [7:0] register_index_pointer_q;
    reg  [7:0] cfg1_q;
    reg  [7:0] cfg2_q;
    reg  [7:0] local_q;
    reg        expect_data_q;

    wire       alias_sel   = cfg1_q[`CFG1_ALIAS];
    wire       range_ext   = cfg1_q[`CFG1_RANGE];
    wire       lock_on     = cfg2_q[`CFG2_LOCK];
    wire [7:0] ptr         = register_index_pointer_q;

    wire [7:0] enc_code;
    wire       enc_clamped;
    wire [7:0] r1_hi;
    wire [7:0] r1_lo;
    wire [7:0] r2_hi;
    wire [7:0] r2_lo;
    wire       r1_frz;
    wire       r2_frz;

    // ****************************************
    // converter side
    // ****************************************
    // encoding uses the range bit live, so the first result landing
    // after a change is already in the new format
    temp_encoder u_enc (
        .deg       (conv_deg),
        .ext_range (range_ext),
        .code      (enc_code),
        .clamped   (enc_clamped)
    );

    // standby suspends measurements; stray converter strobes are dropped
    wire conv_ok  = conv_valid && !cfg1_q[`CFG1_STANDBY];
    wire upd_loc  = conv_ok && (conv_chan == `CHAN_LOCAL);
    wire upd_r1   = conv_ok && (conv_chan == `CHAN_R1);
    wire upd_r2   = conv_ok && (conv_chan == `CHAN_R2);
    // a clamped reading carries no meaningful fraction
    wire [1:0] frac_eff = enc_clamped ? 2'h0 : conv_frac;

    // ****************************************
    // bus read decode
    // ****************************************
    wire rd_r1_lo = rd_req && (ptr == `OFS_R1_LOW)  && !alias_sel;
    wire rd_r1_hi = rd_req && (ptr == `OFS_R1_HIGH) && !alias_sel;
    wire rd_r2_lo = rd_req && ((ptr == `OFS_R2_LOW)
                    || ((ptr == `OFS_R1_LOW) && alias_sel));
    wire rd_r2_hi = rd_req && ((ptr == `OFS_R2_HIGH)
                    || ((ptr == `OFS_R1_HIGH) && alias_sel));

    remote_channel u_r1 (
        .mclk     (mclk),
        .rst_b    (rst_b),
        .upd      (upd_r1),
        .hi_new   (enc_code),
        .frac_new (frac_eff),
        .lo_read  (rd_r1_lo),
        .hi_read  (rd_r1_hi),
        .hi_out   (r1_hi),
        .lo_out   (r1_lo),
        .frozen   (r1_frz)
    );

    remote_channel u_r2 (
        .mclk     (mclk),
        .rst_b    (rst_b),
        .upd      (upd_r2),
        .hi_new   (enc_code),
        .frac_new (frac_eff),
        .lo_read  (rd_r2_lo),
        .hi_read  (rd_r2_hi),
        .hi_out   (r2_hi),
        .lo_out   (r2_lo),
        .frozen   (r2_frz)
    );

    // ****************************************
    // read mux
    // ****************************************
    function [7:0] reg_read;
        input [7:0] addr;
        input       alias_on;
        input [7:0] loc;
        input [7:0] h1;
        input [7:0] l1;
        input [7:0] h2;
        input [7:0] l2;
        input [7:0] c1;
        input [7:0] c2;
        begin
            case (addr)
                `OFS_LOCAL:   reg_read = loc;
                `OFS_R1_HIGH: reg_read = alias_on ? h2 : h1;
                `OFS_R1_LOW:  reg_read = alias_on ? l2 : l1;
                `OFS_R2_HIGH: reg_read = h2;
                `OFS_R2_LOW:  reg_read = l2;
                `OFS_CFG1_RD: reg_read = c1 & `CFG1_RSVD_MASK;
                `OFS_CFG2:    reg_read = c2 & `CFG2_RSVD_MASK;
                default:      reg_read = `UNMAPPED_READ;
            endcase
        end
    endfunction

    // ****************************************
    // bus write decode
    // ****************************************
    wire wr_ptr  = wr_valid && wr_first;
    wire wr_data = wr_valid && !wr_first && expect_data_q;
    // config one write port is a separate offset from its read port;
    // result offsets never decode here so the bus cannot touch them
    wire wr_cfg1 = wr_data && (ptr == `OFS_CFG1_WR) && !lock_on;
    wire wr_cfg2 = wr_data && (ptr == `OFS_CFG2) && !lock_on;

    always @(posedge mclk) begin
        if (!rst_b) begin
            register_index_pointer_q <= `PTR_RESET;
            expect_data_q            <= 1'b0;
            cfg1_q                   <= `CFG1_RESET;
            cfg2_q                   <= `CFG2_RESET;
            local_q                  <= `RESULT_RESET;
            rd_data                  <= 8'h00;
            rd_valid                 <= 1'b0;
            r1_frozen                <= 1'b0;
            r2_frozen                <= 1'b0;
        end else begin
            if (wr_ptr) begin
                register_index_pointer_q <= wr_byte;
                expect_data_q            <= 1'b1;
            end else if (wr_data) begin
                // bytes past the second one are ignored
                expect_data_q <= 1'b0;
            end
            if (wr_cfg1) begin
                cfg1_q <= wr_byte & `CFG1_RSVD_MASK;
            end
            if (wr_cfg2) begin
                // lock only clears with a reset, a stand-in for power cycle
                cfg2_q <= wr_byte & `CFG2_RSVD_MASK;
            end
            if (upd_loc) begin
                local_q <= enc_code;
            end
            rd_valid <= rd_req;
            if (rd_req) begin
                rd_data <= reg_read(ptr, alias_sel, local_q, r1_hi, r1_lo,
                                    r2_hi, r2_lo, cfg1_q, cfg2_q);
            end
            r1_frozen <= r1_frz;
            r2_frozen <= r2_frz;
        end
    end

    assign pointer   = register_index_pointer_q;
    assign cfg_one   = cfg1_q;
    assign cfg_two   = cfg2_q;
    assign ext_range = cfg1_q[`CFG1_RANGE];
    assign standby   = cfg1_q[`CFG1_STANDBY];
    assign locked    = cfg2_q[`CFG2_LOCK];
endmodule // temp_result_register_map

// *** src/temp_result_regs.vh ***
`ifndef TEMP_RESULT_REGS_VH
`define TEMP_RESULT_REGS_VH

// ****************************************
// register offsets
// ****************************************
`define OFS_LOCAL         8'h00
`define OFS_R1_HIGH       8'h01
`define OFS_CFG1_RD       8'h03
`define OFS_CFG1_WR       8'h09
`define OFS_R1_LOW        8'h10
`define OFS_CFG2          8'h24
`define OFS_R2_HIGH       8'h30
`define OFS_R2_LOW        8'h33

// ****************************************
// field positions
// ****************************************
`define CFG1_STANDBY      6
`define CFG1_ALIAS        3
`define CFG1_RANGE        2
`define CFG2_LOCK         7
`define CFG1_RSVD_MASK    8'hef
`define CFG2_RSVD_MASK    8'h80
`define LOW_FRAC_SHIFT    6

// ****************************************
// reset values and constants
// ****************************************
`define PTR_RESET         8'h00
`define RESULT_RESET      8'h00
`define CFG1_RESET        8'h00
`define CFG2_RESET        8'h00
`define UNMAPPED_READ     8'h00
`define EXT_OFFSET        11'sd64
`define DEF_MAX           11'sd127
`define EXT_MAX           11'sd255

// ****************************************
// converter channel codes
// ****************************************
`define CHAN_LOCAL        2'h0
`define CHAN_R1           2'h1
`define CHAN_R2           2'h2

`endif

// *** verif/host_model.sv ***
`timescale 1ns/10ps
// ********
// serial host
// ********
module host_model (
    output reg        wr_valid,
    output reg        wr_first,
    output reg  [7:0] wr_byte,
    output reg        rd_req,
    input  wire       mclk,
    input  wire [7:0] rd_data,
    input  wire       rd_valid
);
    initial begin
        wr_valid = 1'b0;
        wr_first = 1'b0;
        wr_byte  = 8'h00;
        rd_req   = 1'b0;
    end
    task put(input [7:0] b, input f);
        @(posedge mclk);
        wr_valid <= 1'b1;
        wr_first <= f;
        wr_byte  <= b;
        @(posedge mclk);
        wr_valid <= 1'b0;
        wr_byte  <= ~b; // released bus must not look stale
    endtask
    task wr(input [7:0] a, input [7:0] d);
        put(a, 1'b1);
        put(d, 1'b0);
    endtask
    task rd_here(output [7:0] d);
        @(posedge mclk);
        rd_req <= 1'b1;
        @(posedge mclk);
        rd_req <= 1'b0;
        // answer stands at the next edge; take it there, before it is cleared
        @(posedge mclk);
        d = rd_valid ? rd_data : 8'hxx;
    endtask
    // pointer byte alone, then the read
    task rd(input [7:0] a, output [7:0] d);
        put(a, 1'b1);
        rd_here(d);
    endtask
endmodule // host_model

// *** verif/temp_result_register_map_monitor.sv ***
`timescale 1ns/10ps
// ********
// checker
// ********
module temp_result_register_map_monitor (
    input wire       mclk,
    input wire       rst_b,
    input wire       wr_valid,
    input wire       wr_first,
    input wire [7:0] wr_byte,
    input wire       rd_req,
    input wire [7:0] rd_data,
    input wire       rd_valid,
    input wire [7:0] pointer,
    input wire [7:0] cfg_one,
    input wire [7:0] cfg_two,
    input wire       ext_range,
    input wire       locked,
    input wire       standby,
    input wire       r1_frozen,
    input wire       r2_frozen
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    read_answer_a: assert property (rd_valid == $past(rd_req))
        else $error("read answer mistimed");
    ptr_load_a: assert property (wr_valid && wr_first |=> pointer == $past(wr_byte))
        else $error("pointer not loaded");
    ptr_reset_a: assert property ($rose(rst_b) |-> pointer == 8'h00)
        else $error("pointer not cleared");
    range_bit_a: assert property (ext_range == cfg_one[2])
        else $error("range flag disagrees");
    lock_hold_a: assert property (locked |=> locked)
        else $error("lock dropped");
    lock_block_a: assert property (locked && wr_valid && !wr_first
        |=> $stable(cfg_one) && $stable(cfg_two)) else $error("locked write took effect");
    unmapped_read_a: assert property (rd_req && pointer == 8'h09 |=> rd_data == 8'h00)
        else $error("write port readable");
    cfg_read_a: assert property (rd_req && pointer == 8'h03 |=> rd_data == $past(cfg_one))
        else $error("config read wrong");
    low_frac_a: assert property (rd_req && (pointer == 8'h10 || pointer == 8'h33)
        |=> rd_data[5:0] == 6'h00) else $error("low byte bits set");
    freeze_set_a: assert property (rd_req && pointer == 8'h10 && !cfg_one[3]
        |-> ##2 r1_frozen) else $error("high byte not frozen");
    freeze_two_a: assert property (rd_req && pointer == 8'h33 |-> ##2 r2_frozen)
        else $error("second high byte not frozen");
    standby_bit_a: assert property (standby == cfg_one[6])
        else $error("standby flag disagrees");
endmodule // temp_result_register_map_monitor

bind temp_result_register_map temp_result_register_map_monitor i_mon (
    .mclk, .rst_b, .wr_valid, .wr_first, .wr_byte, .rd_req, .rd_data, .rd_valid,
    .pointer, .cfg_one, .cfg_two, .ext_range, .locked, .standby, .r1_frozen, .r2_frozen
);

// *** verif/testbench.sv ***
`timescale 1ns/10ps
// ********
// bench
// ********
module testbench;
    reg         mclk;
    reg         rst_b;
    reg         conv_valid;
    reg  [1:0]  conv_chan;
    reg  [9:0]  conv_deg;
    reg  [1:0]  conv_frac;
    wire        wr_valid, wr_first, rd_req, rd_valid;
    wire [7:0]  wr_byte, rd_data;
    reg  [15:0] seed;
    reg  [7:0]  got, cfg;
    reg  [7:0]  eh [0:2];
    reg  [7:0]  el [0:2];
    reg  [39:0] ofs;
    integer     fail_count, n_compared, cyc, i, k, t, a;

    temp_result_register_map i_temp_result_register_map (
        .mclk, .rst_b, .wr_valid, .wr_first, .wr_byte, .rd_req, .conv_valid, .conv_chan,
        .conv_deg, .conv_frac, .rd_data, .rd_valid, .pointer(), .cfg_one(), .cfg_two(),
        .ext_range(), .standby(), .locked(), .r1_frozen(), .r2_frozen()
    );
    host_model i_host_model (.mclk, .wr_valid, .wr_first, .wr_byte, .rd_req, .rd_data, .rd_valid);

    function [15:0] lfsr(input [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // {clamped, code}
    function [8:0] enc(input integer d, input ext);
        integer v;
        begin
            v = ext ? d + 64 : d;
            if (v < 0)
                enc = 9'h100;
            else if (v > (ext ? 255 : 127))
                enc = {1'b1, ext ? 8'hff : 8'h7f};
            else
                enc = {1'b0, v[7:0]};
        end
    endfunction
    task check(input [7:0] seen, input [7:0] exp);
        n_compared = n_compared + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("unexpected at %0t: read %h wanted %h", $time, seen, exp);
        end
    endtask
    task conv(input [1:0] ch, input integer d, input [1:0] f, input ext);
        reg [8:0] e;
        @(posedge mclk);
        conv_valid <= 1'b1;
        conv_chan  <= ch;
        conv_deg   <= d[9:0];
        conv_frac  <= f;
        @(posedge mclk);
        conv_valid <= 1'b0;
        e = enc(d, ext);
        eh[ch] = e[7:0];
        el[ch] = (e[8] && !ext) ? 8'h00 : {f, 6'h00};
    endtask
    task rdc(input [7:0] o, input [7:0] exp);
        i_host_model.rd(o, got);
        check(got, exp);
    endtask
    task report_and_stop;
        $display("compared %0d mismatched %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // run needs about 1700 cycles
    always @(posedge mclk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            fail_count = fail_count + 1;
            report_and_stop;
        end
    end

    initial begin
        rst_b = 1'b0;
        conv_valid = 1'b0;
        conv_chan = 2'h3;
        conv_deg = 10'h000;
        conv_frac = 2'h0;
        seed = 16'h820b;
        ofs = 40'h0001103033;
        fail_count = 0;
        n_compared = 0;
        cyc = 0;
        for (k = 0; k < 3; k = k + 1) begin
            eh[k] = 8'h00;
            el[k] = 8'h00;
        end
        repeat (6) @(posedge mclk);
        rst_b <= 1'b1;
        i_host_model.rd_here(got);
        check(got, 8'h00);
        for (k = 0; k < 5; k = k + 1)
            rdc(ofs[39-8*k -: 8], 8'h00);
        for (i = 0; i < 40; i = i + 1) begin
            seed = lfsr(seed);
            cfg = seed[7:0] & 8'hbf; // standby would drop conversions
            if (i < 6)
                cfg[2] = i[1];
            i_host_model.wr(8'h09, cfg);
            rdc(8'h03, cfg & 8'hef);
            for (k = 0; k < 3; k = k + 1) begin
                seed = lfsr(seed);
                t = seed[15:8];
                t = (i < 6) ? ((i % 2) ? 191 : -64) : t - 64;
                conv(k[1:0], t, seed[3:2], cfg[2]);
            end
            a = cfg[3] ? 2 : 1;
            rdc(8'h00, eh[0]);
            rdc(8'h10, el[a]);
            rdc(8'h01, eh[a]);
            rdc(8'h33, el[2]);
            rdc(8'h30, eh[2]);
        end
        i_host_model.wr(8'h09, 8'h00);
        conv(2'h1, 20, 2'h1, 1'b0);
        rdc(8'h10, 8'h40);
        conv(2'h1, 50, 2'h0, 1'b0);
        rdc(8'h01, 8'h14);
        rdc(8'h01, 8'h32);
        i_host_model.wr(8'h00, 8'h5a);
        rdc(8'h00, eh[0]);
        i_host_model.wr(8'h09, 8'h40);
        rdc(8'h03, 8'h40);
        cfg = eh[0];
        conv(2'h0, 99, 2'h0, 1'b0);
        rdc(8'h00, cfg);
        eh[0] = cfg;
        i_host_model.wr(8'h09, 8'h00);
        rdc(8'h09, 8'h00);
        i_host_model.wr(8'h24, 8'hff);
        rdc(8'h24, 8'h80);
        i_host_model.wr(8'h09, 8'h04);
        rdc(8'h03, 8'h00);
        @(posedge mclk);
        rst_b <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        i_host_model.rd_here(got);
        check(got, 8'h00);
        rdc(8'h24, 8'h00);
        report_and_stop;
    end
endmodule // testbench
